// ### csb_core_sfr_bank.v
// Core special-function-register bank with its side effects
// Assumes the core drives all requests synchronously, one per cycle
// Behaviour
// - Index pointer is page, high, low bytes; increment carries high into page.
// - Push or call increments stack pointer first, then writes at new location.
// - Reset loads stack top pointer with 07h; first push lands at 08h.
// - Three upper stack bits sit in low bits of upper-bits register at B7h.
// - Upper-bits register neither reads nor writes while wide stack is off.
// - With wide stack on, pointer advances 00FFh to 0100h into on-chip RAM.
// - With wide stack off, 8-bit pointer wraps FFh to 00h.
// - Memory configuration register reads 00h after reset.
// - Map enable puts on-chip extended RAM in lowest 2 kbytes of data space.
// - Map disabled sends extended data accesses to external memory, 16 MB.
// - Status word: carry 7, half carry 6, user 5, overflow 2, user 1, parity 0.
// - Status word bits 4 and 3 pick working register bank 0 to 3.
// - Status word is bit addressable at D0h, resets to 00h.
// - Power control bit 7 doubles serial baud rate.
// - Power control bit 6 lets serial interrupt end power-down.
// - Power control bit 5 lets pin interrupt end power-down, level or falling edge.
// - Power control bit 4 disables address latch strobe.
// - Writing one to power control bit 1 enters power-down.
// - Power control bits 3,2 are plain flags; bit 0 ignores writes.
// - Helper register serves multiply/divide, otherwise a scratch register.
`timescale 1ns/1ps
`include "csb_defs.vh"
module csb_core_sfr_bank
(
   input  wire        i_sys_clk,
   input  wire        i_rst_b,
   input  wire [7:0]  i_sfr_addr,
   input  wire        i_sfr_wr,
   input  wire        i_sfr_rd,
   input  wire [7:0]  i_sfr_wdata,
   input  wire        i_bit_wr,
   input  wire [7:0]  i_bit_addr,
   input  wire        i_bit_wdata,
   input  wire        i_stk_push,
   input  wire        i_stk_pop,
   input  wire        i_index_inc,
   input  wire        i_index_ld16,
   input  wire [15:0] i_index_wdata,
   input  wire        i_mul_go,
   input  wire        i_div_go,
   input  wire [7:0]  i_acc,
   input  wire        i_alu_flag_we,
   input  wire        i_alu_carry,
   input  wire        i_alu_half_carry,
   input  wire        i_alu_range_err,
   input  wire [23:0] i_xdata_addr,
   input  wire        i_serial_irq,
   input  wire        i_ext_int_zero_pin,
   input  wire        i_ext_int_zero_edge_select,
   output reg  [7:0]  o_sfr_rdata,
   output reg         o_sfr_hit,
   output reg  [10:0] o_stk_addr,
   output reg         o_stk_we,
   output reg  [23:0] o_memory_index_pointer,
   output reg  [7:0]  o_acc_result,
   output reg         o_acc_result_valid,
   output reg  [1:0]  o_bank_sel,
   output reg         o_baud_doubler,
   output reg         o_latch_strobe_en,
   output reg         o_sleep,
   output reg         o_xdata_onchip
);
   // ==============================================
   // Reset release
   reg        rst_meta_reg;
   reg        rst_sync_reg;
   wire       rst_s_b;

   always @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_s_b = rst_sync_reg;

   // ==============================================
   // Registers
   reg [7:0]  stack_top_pointer_reg;
   reg [7:0]  stack_top_pointer_next;
   reg [7:0]  stack_upper_bits_reg;
   reg [7:0]  stack_upper_bits_next;
   reg [7:0]  memory_config_reg;
   reg [7:0]  memory_config_next;
   reg [7:0]  power_control_reg;
   reg [7:0]  power_control_next;
   reg [7:0]  cpu_status_word_reg;
   reg [7:0]  cpu_status_word_next;
   reg [7:0]  helper_reg;
   reg [7:0]  helper_next;
   reg [7:0]  index_low_byte_reg;
   reg [7:0]  index_high_byte_reg;
   reg [7:0]  index_page_byte_reg;
   reg [23:0] index_next;
   reg        pin_prev_reg;

   wire       wide_stack_enable;
   wire       onchip_xdata_map_enable;
   wire [10:0] stk_full;
   wire [10:0] stk_inc;
   wire [10:0] stk_dec;
   wire [7:0] md_acc;
   wire [7:0] md_helper;
   wire       md_err;
   wire       md_go;
   wire       wake;
   wire       sw_bit_hit;
   wire [7:0] sw_bit_mask;

   assign wide_stack_enable       = memory_config_reg[`CSB_MC_WIDE_STACK];
   assign onchip_xdata_map_enable = memory_config_reg[`CSB_MC_XDATA_MAP];
   assign stk_full = {stack_upper_bits_reg[2:0] & {3{wide_stack_enable}}, stack_top_pointer_reg};
   assign stk_inc  = stk_full + 11'h001;
   assign stk_dec  = stk_full - 11'h001;
   assign md_go    = i_mul_go | i_div_go;
   // Status word occupies bit addresses D0h..D7h
   assign sw_bit_hit  = i_bit_wr && ((i_bit_addr & 8'hf8) == `CSB_ADDR_STATUS_WORD);
   assign sw_bit_mask = 8'h01 << i_bit_addr[2:0];

   // Wake sources; level mode looks for a low pin
   assign wake = (power_control_reg[`CSB_PC_SERIAL_WAKE] & i_serial_irq)
               | (power_control_reg[`CSB_PC_EXT_WAKE]
                  & (i_ext_int_zero_edge_select ? (pin_prev_reg & ~i_ext_int_zero_pin)
                                                : ~i_ext_int_zero_pin));

   csb_muldiv u_muldiv
   (
      .i_div        (i_div_go),
      .i_acc        (i_acc),
      .i_helper     (helper_reg),
      .o_acc_out    (md_acc),
      .o_helper_out (md_helper),
      .o_range_err  (md_err)
   );

   // ==============================================
   // Stack pointer next state
   // Register writes win over push/pop in the same cycle
   always @*
   begin
      stack_top_pointer_next = stack_top_pointer_reg;
      stack_upper_bits_next  = stack_upper_bits_reg;
      if (i_stk_push)
      begin
         if (wide_stack_enable)
         begin
            stack_top_pointer_next = stk_inc[7:0];
            stack_upper_bits_next  = {5'h00, stk_inc[10:8]};
         end
         else
         begin
            stack_top_pointer_next = stk_inc[7:0];
         end
      end
      else if (i_stk_pop)
      begin
         if (wide_stack_enable)
         begin
            stack_top_pointer_next = stk_dec[7:0];
            stack_upper_bits_next  = {5'h00, stk_dec[10:8]};
         end
         else
         begin
            stack_top_pointer_next = stk_dec[7:0];
         end
      end
      if (i_sfr_wr && i_sfr_addr == `CSB_ADDR_STACK_TOP)
      begin
         stack_top_pointer_next = i_sfr_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == `CSB_ADDR_STACK_UPPER && wide_stack_enable)
      begin
         stack_upper_bits_next = i_sfr_wdata & `CSB_SU_WRITE_MASK;
      end
   end

   // ==============================================
   // Index pointer next state
   always @*
   begin
      index_next = {index_page_byte_reg, index_high_byte_reg, index_low_byte_reg};
      if (i_index_inc)
      begin
         index_next = index_next + 24'h000001;
      end
      else if (i_index_ld16)
      begin
         index_next[15:0] = i_index_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == `CSB_ADDR_INDEX_LOW)
      begin
         index_next[7:0] = i_sfr_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == `CSB_ADDR_INDEX_HIGH)
      begin
         index_next[15:8] = i_sfr_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == `CSB_ADDR_INDEX_PAGE)
      begin
         index_next[23:16] = i_sfr_wdata;
      end
   end

   // ==============================================
   // Status word, helper, config and power next state
   always @*
   begin
      cpu_status_word_next = cpu_status_word_reg;
      helper_next          = helper_reg;
      memory_config_next   = memory_config_reg;
      power_control_next   = power_control_reg;
      if (i_alu_flag_we)
      begin
         cpu_status_word_next[`CSB_SW_CARRY]      = i_alu_carry;
         cpu_status_word_next[`CSB_SW_HALF_CARRY] = i_alu_half_carry;
         cpu_status_word_next[`CSB_SW_RANGE_ERR]  = i_alu_range_err;
      end
      if (md_go)
      begin
         helper_next                             = md_helper;
         cpu_status_word_next[`CSB_SW_CARRY]     = 1'b0;
         cpu_status_word_next[`CSB_SW_RANGE_ERR] = md_err;
      end
      if (sw_bit_hit)
      begin
         cpu_status_word_next = (cpu_status_word_next & ~sw_bit_mask)
                              | ({8{i_bit_wdata}} & sw_bit_mask);
      end
      if (i_sfr_wr)
      begin
         case (i_sfr_addr)
            `CSB_ADDR_STATUS_WORD:
               cpu_status_word_next = i_sfr_wdata;
            `CSB_ADDR_MULDIV_HELPER:
               helper_next = i_sfr_wdata;
            `CSB_ADDR_MEM_CONFIG:
               memory_config_next = i_sfr_wdata & `CSB_MC_WRITE_MASK;
            `CSB_ADDR_POWER_CTRL:
               power_control_next = i_sfr_wdata & `CSB_PC_WRITE_MASK;
            default:
               helper_next = helper_next;
         endcase
      end
      // Parity always tracks the accumulator, so writes cannot stick
      cpu_status_word_next[`CSB_SW_PARITY] = ^i_acc;
      // Wake clears the sleep request; a fresh write in the same cycle wins
      if (wake && !(i_sfr_wr && i_sfr_addr == `CSB_ADDR_POWER_CTRL))
      begin
         power_control_next[`CSB_PC_SLEEP_REQ] = 1'b0;
      end
   end

   // ==============================================
   // State registers
   always @(posedge i_sys_clk or negedge rst_s_b)
   begin
      if (!rst_s_b)
      begin
         stack_top_pointer_reg <= `CSB_RST_STACK_TOP;
         stack_upper_bits_reg  <= `CSB_RST_ZERO;
         memory_config_reg     <= `CSB_RST_MEM_CONFIG;
         power_control_reg     <= `CSB_RST_POWER_CTRL;
         cpu_status_word_reg   <= `CSB_RST_STATUS_WORD;
         helper_reg            <= `CSB_RST_ZERO;
         index_low_byte_reg    <= `CSB_RST_ZERO;
         index_high_byte_reg   <= `CSB_RST_ZERO;
         index_page_byte_reg   <= `CSB_RST_ZERO;
         pin_prev_reg          <= 1'b1;
      end
      else
      begin
         stack_top_pointer_reg <= stack_top_pointer_next;
         stack_upper_bits_reg  <= stack_upper_bits_next;
         memory_config_reg     <= memory_config_next;
         power_control_reg     <= power_control_next;
         cpu_status_word_reg   <= cpu_status_word_next;
         helper_reg            <= helper_next;
         index_low_byte_reg    <= index_next[7:0];
         index_high_byte_reg   <= index_next[15:8];
         index_page_byte_reg   <= index_next[23:16];
         pin_prev_reg          <= i_ext_int_zero_pin;
      end
   end

   // ==============================================
   // Outputs and read path
   always @(posedge i_sys_clk or negedge rst_s_b)
   begin
      if (!rst_s_b)
      begin
         o_sfr_rdata            <= 8'h00;
         o_sfr_hit              <= 1'b0;
         o_stk_addr             <= 11'h000;
         o_stk_we               <= 1'b0;
         o_memory_index_pointer <= 24'h000000;
         o_acc_result           <= 8'h00;
         o_acc_result_valid     <= 1'b0;
         o_bank_sel             <= 2'h0;
         o_baud_doubler         <= 1'b0;
         o_latch_strobe_en      <= 1'b1;
         o_sleep                <= 1'b0;
         o_xdata_onchip         <= 1'b0;
      end
      else
      begin
         // Push writes at the incremented pointer; pop reads old top
         o_stk_we   <= i_stk_push;
         o_stk_addr <= i_stk_push ? {stack_upper_bits_next[2:0] & {3{wide_stack_enable}}, stack_top_pointer_next}
                                  : stk_full;
         o_memory_index_pointer <= index_next;
         o_acc_result           <= md_acc;
         o_acc_result_valid     <= md_go;
         o_bank_sel     <= {cpu_status_word_next[`CSB_SW_BANK_HI],
                            cpu_status_word_next[`CSB_SW_BANK_LO]};
         o_baud_doubler <= power_control_next[`CSB_PC_BAUD_DOUBLER];
         o_latch_strobe_en <= ~power_control_next[`CSB_PC_STROBE_OFF];
         o_sleep        <= power_control_next[`CSB_PC_SLEEP_REQ];
         // Only the low 2 kbytes go on chip, the rest stays external
         o_xdata_onchip <= onchip_xdata_map_enable
                           && (i_xdata_addr <= `CSB_XDATA_ONCHIP_TOP);
         o_sfr_hit   <= 1'b0;
         o_sfr_rdata <= 8'h00;
         if (i_sfr_rd)
         begin
            o_sfr_hit <= 1'b1;
            case (i_sfr_addr)
               `CSB_ADDR_STACK_TOP:     o_sfr_rdata <= stack_top_pointer_reg;
               `CSB_ADDR_STACK_UPPER:
               begin
                  // Disabled register stays silent
                  o_sfr_rdata <= wide_stack_enable ? stack_upper_bits_reg : 8'h00;
                  o_sfr_hit   <= wide_stack_enable;
               end
               `CSB_ADDR_INDEX_LOW:     o_sfr_rdata <= index_low_byte_reg;
               `CSB_ADDR_INDEX_HIGH:    o_sfr_rdata <= index_high_byte_reg;
               `CSB_ADDR_INDEX_PAGE:    o_sfr_rdata <= index_page_byte_reg;
               `CSB_ADDR_POWER_CTRL:    o_sfr_rdata <= power_control_reg;
               `CSB_ADDR_MEM_CONFIG:    o_sfr_rdata <= memory_config_reg;
               `CSB_ADDR_STATUS_WORD:   o_sfr_rdata <= cpu_status_word_reg;
               `CSB_ADDR_MULDIV_HELPER: o_sfr_rdata <= helper_reg;
               default:                 o_sfr_hit   <= 1'b0;
            endcase
         end
      end
   end
endmodule

// ### csb_defs.vh
// Constants for the core special-function-register bank
// Assumes inclusion by csb_core_sfr_bank.v and csb_muldiv.v only
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH
// ==============================================
// Register addresses
`define CSB_ADDR_STACK_TOP     8'h81
`define CSB_ADDR_INDEX_LOW     8'h82
`define CSB_ADDR_INDEX_HIGH    8'h83
`define CSB_ADDR_INDEX_PAGE    8'h84
`define CSB_ADDR_POWER_CTRL    8'h87
`define CSB_ADDR_MEM_CONFIG    8'haf
`define CSB_ADDR_STACK_UPPER   8'hb7
`define CSB_ADDR_STATUS_WORD   8'hd0
`define CSB_ADDR_MULDIV_HELPER 8'hf0
// ==============================================
// Reset values
`define CSB_RST_STACK_TOP      8'h07
`define CSB_RST_POWER_CTRL     8'h00
`define CSB_RST_MEM_CONFIG     8'h00
`define CSB_RST_STATUS_WORD    8'h00
`define CSB_RST_ZERO           8'h00
// ==============================================
// Status word fields
`define CSB_SW_CARRY           7
`define CSB_SW_HALF_CARRY      6
`define CSB_SW_USER0           5
`define CSB_SW_BANK_HI         4
`define CSB_SW_BANK_LO         3
`define CSB_SW_RANGE_ERR       2
`define CSB_SW_USER1           1
`define CSB_SW_PARITY          0
// ==============================================
// Power control fields
`define CSB_PC_BAUD_DOUBLER    7
`define CSB_PC_SERIAL_WAKE     6
`define CSB_PC_EXT_WAKE        5
`define CSB_PC_STROBE_OFF      4
`define CSB_PC_SPARE1          3
`define CSB_PC_SPARE0          2
`define CSB_PC_SLEEP_REQ       1
`define CSB_PC_WRITE_MASK      8'hfe
// ==============================================
// Memory configuration fields
`define CSB_MC_WIDE_STACK      7
`define CSB_MC_XDATA_MAP       0
`define CSB_MC_WRITE_MASK      8'h81
`define CSB_SU_WRITE_MASK      8'h07
// ==============================================
// Extended data map
`define CSB_XDATA_ONCHIP_TOP   24'h0007ff
`endif

// ### csb_muldiv.v
// Multiply and divide of accumulator by the helper register
// Assumes operands are stable for the cycle they are sampled
`timescale 1ns/1ps
`include "csb_defs.vh"
module csb_muldiv
(
   input  wire       i_div,
   input  wire [7:0] i_acc,
   input  wire [7:0] i_helper,
   output reg  [7:0] o_acc_out,
   output reg  [7:0] o_helper_out,
   output reg        o_range_err
);
   reg [15:0] prod;

   // ==============================================
   // Combinational arithmetic
   always @*
   begin
      prod = {8'h00, i_acc} * {8'h00, i_helper};
      if (i_div)
      begin
         // Divide by zero leaves operands, flags error
         if (i_helper == `CSB_RST_ZERO)
         begin
            o_acc_out    = i_acc;
            o_helper_out = i_helper;
            o_range_err  = 1'b1;
         end
         else
         begin
            o_acc_out    = i_acc / i_helper;
            o_helper_out = i_acc % i_helper;
            o_range_err  = 1'b0;
         end
      end
      else
      begin
         o_acc_out    = prod[7:0];
         o_helper_out = prod[15:8];
         o_range_err  = (prod[15:8] != `CSB_RST_ZERO);
      end
   end
endmodule

// ### csb_core_sfr_bank_chk.sv
// Checker for the core register bank, bound to its ports
// Assumes the core issues at most one register write per cycle
`timescale 1ns/1ps
module csb_core_sfr_bank_chk
(
   input wire        i_sys_clk,
   input wire        i_rst_b,
   input wire [7:0]  i_sfr_addr,
   input wire        i_sfr_wr,
   input wire        i_sfr_rd,
   input wire [7:0]  i_sfr_wdata,
   input wire        i_stk_push,
   input wire        i_mul_go,
   input wire [23:0] i_xdata_addr,
   input wire        i_serial_irq,
   input wire [7:0]  o_sfr_rdata,
   input wire        o_sfr_hit,
   input wire [10:0] o_stk_addr,
   input wire        o_stk_we,
   input wire        o_acc_result_valid,
   input wire [1:0]  o_bank_sel,
   input wire        o_baud_doubler,
   input wire        o_latch_strobe_en,
   input wire        o_sleep,
   input wire        o_xdata_onchip
);
// ==============================================
// Shadows of what the core wrote
reg [7:0] pc_reg;
reg [7:0] mc_reg;
always @(posedge i_sys_clk or negedge i_rst_b)
begin
   if (!i_rst_b)
   begin
      pc_reg <= 8'h00;
      mc_reg <= 8'h00;
   end
   else if (i_sfr_wr)
   begin
      if (i_sfr_addr == 8'h87)
         pc_reg <= i_sfr_wdata;
      if (i_sfr_addr == 8'haf)
         mc_reg <= i_sfr_wdata;
   end
end
// ==============================================
// Properties
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (!i_rst_b);
a_upper_blocked: assert property (i_sfr_rd && i_sfr_addr == 8'hb7 && !mc_reg[7] |=> o_sfr_rdata == 8'h00 && !o_sfr_hit)
   else $error("upper stack byte visible while narrow");
a_push_strobe: assert property (i_stk_push |=> o_stk_we)
   else $error("push gave no write strobe");
a_no_stray: assert property (!i_stk_push |=> !o_stk_we)
   else $error("write strobe without push");
a_push_advance: assert property ((i_stk_push && !i_sfr_wr)[*2] |=> o_stk_addr[7:0] == $past(o_stk_addr[7:0]) + 8'h01)
   else $error("stack address did not advance by one");
a_narrow_upper: assert property (o_stk_we && !mc_reg[7] |-> o_stk_addr[10:8] == 3'h0)
   else $error("narrow stack left the low page");
a_sleep_enter: assert property (i_sfr_wr && i_sfr_addr == 8'h87 && i_sfr_wdata[1] |=> o_sleep)
   else $error("sleep request ignored");
a_serial_wake: assert property (o_sleep && i_serial_irq && pc_reg[6] && !i_sfr_wr |=> !o_sleep)
   else $error("serial wake ignored");
a_power_outs: assert property (i_sfr_wr && i_sfr_addr == 8'h87 |=> o_baud_doubler == pc_reg[7] && o_latch_strobe_en == !pc_reg[4])
   else $error("power control outputs wrong");
a_bank_follows: assert property (i_sfr_wr && i_sfr_addr == 8'hd0 |=> o_bank_sel == $past(i_sfr_wdata[4:3]))
   else $error("bank select wrong");
a_map_offchip: assert property (i_xdata_addr > 24'h0007ff || !mc_reg[0] |=> !o_xdata_onchip)
   else $error("access wrongly kept on chip");
a_map_onchip: assert property (i_xdata_addr <= 24'h0007ff && mc_reg[0] |=> o_xdata_onchip)
   else $error("mapped access sent off chip");
a_mul_done: assert property (i_mul_go |=> o_acc_result_valid)
   else $error("multiply gave no result");
endmodule
bind csb_core_sfr_bank csb_core_sfr_bank_chk u_chk (.i_sys_clk, .i_rst_b, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
   .i_sfr_wdata, .i_stk_push, .i_mul_go, .i_xdata_addr, .i_serial_irq, .o_sfr_rdata, .o_sfr_hit, .o_stk_addr,
   .o_stk_we, .o_acc_result_valid, .o_bank_sel, .o_baud_doubler, .o_latch_strobe_en, .o_sleep, .o_xdata_onchip);

// ### csb_core_model.sv
// Behavioural core issuing bank requests
// Assumes the bank samples every request on the rising clock edge
`timescale 1ns/1ps
module csb_core_model
(
   input  wire        i_sys_clk,
   output reg  [7:0]  o_sfr_addr,
   output reg         o_sfr_wr,
   output reg         o_sfr_rd,
   output reg  [7:0]  o_sfr_wdata,
   output reg         o_bit_wr,
   output reg  [7:0]  o_bit_addr,
   output reg         o_bit_wdata,
   output reg         o_stk_push,
   output reg         o_stk_pop,
   output reg         o_index_inc,
   output reg         o_index_ld16,
   output reg  [15:0] o_index_wdata,
   output reg         o_mul_go,
   output reg         o_div_go,
   output reg  [7:0]  o_acc,
   output reg         o_alu_flag_we,
   output reg         o_alu_carry,
   output reg         o_alu_half_carry,
   output reg         o_alu_range_err,
   output reg  [23:0] o_xdata_addr,
   output reg         o_serial_irq,
   output reg         o_ext_int_zero_pin,
   output reg         o_ext_int_zero_edge_select
);
// ==============================================
// Idle levels; the pin idles high
initial
begin
   {o_sfr_addr, o_sfr_wr, o_sfr_rd, o_sfr_wdata, o_bit_wr, o_bit_addr, o_bit_wdata, o_stk_push, o_stk_pop,
    o_index_inc, o_index_ld16, o_index_wdata, o_mul_go, o_div_go, o_acc, o_alu_flag_we, o_alu_carry,
    o_alu_half_carry, o_alu_range_err, o_xdata_addr, o_serial_irq, o_ext_int_zero_edge_select} = 0;
   o_ext_int_zero_pin = 1'b1;
end
// ==============================================
// Kinds: 0 wr 1 rd 2 bit 3 push 4 pop 5 inc 6 ld16 7 mul 8 div 9 alu
task set_kind(input integer k, input reg v);
begin
   case (k)
      0: o_sfr_wr <= v;
      1: o_sfr_rd <= v;
      2: o_bit_wr <= v;
      3: o_stk_push <= v;
      4: o_stk_pop <= v;
      5: o_index_inc <= v;
      6: o_index_ld16 <= v;
      7: o_mul_go <= v;
      8: o_div_go <= v;
      default: o_alu_flag_we <= v;
   endcase
end
endtask
// Strobe held n cycles; qualifiers stay put until it drops
task req(input integer k, input [7:0] a, input [7:0] d, input integer n);
begin
   @(posedge i_sys_clk);
   o_sfr_addr    <= a;
   o_sfr_wdata   <= d;
   o_bit_addr    <= a;
   o_bit_wdata   <= d[0];
   o_index_wdata <= {a, d};
   set_kind(k, 1'b1);
   repeat (n) @(posedge i_sys_clk);
   set_kind(k, 1'b0);
end
endtask
endmodule

// ### core_sfr_stack_config_tb_top.sv
// Testbench for the core register bank
// Assumes the core model drives all requests on rising edges
`timescale 1ns/1ps
module core_sfr_stack_config_tb_top;
reg         i_sys_clk;
reg         i_rst_b;
wire [7:0]  i_sfr_addr;
wire        i_sfr_wr;
wire        i_sfr_rd;
wire [7:0]  i_sfr_wdata;
wire        i_bit_wr;
wire [7:0]  i_bit_addr;
wire        i_bit_wdata;
wire        i_stk_push;
wire        i_stk_pop;
wire        i_index_inc;
wire        i_index_ld16;
wire [15:0] i_index_wdata;
wire        i_mul_go;
wire        i_div_go;
wire [7:0]  i_acc;
wire        i_alu_flag_we;
wire        i_alu_carry;
wire        i_alu_half_carry;
wire        i_alu_range_err;
wire [23:0] i_xdata_addr;
wire        i_serial_irq;
wire        i_ext_int_zero_pin;
wire        i_ext_int_zero_edge_select;
wire [7:0]  o_sfr_rdata;
wire        o_sfr_hit;
wire [10:0] o_stk_addr;
wire        o_stk_we;
wire [23:0] o_memory_index_pointer;
wire [7:0]  o_acc_result;
wire        o_acc_result_valid;
wire [1:0]  o_bank_sel;
wire        o_baud_doubler, o_latch_strobe_en, o_sleep, o_xdata_onchip;
integer     num_errors;
integer     cmp_count;
csb_core_model u_core (.i_sys_clk, .o_sfr_addr(i_sfr_addr), .o_sfr_wr(i_sfr_wr), .o_sfr_rd(i_sfr_rd),
   .o_sfr_wdata(i_sfr_wdata), .o_bit_wr(i_bit_wr), .o_bit_addr(i_bit_addr), .o_bit_wdata(i_bit_wdata),
   .o_stk_push(i_stk_push), .o_stk_pop(i_stk_pop), .o_index_inc(i_index_inc), .o_index_ld16(i_index_ld16),
   .o_index_wdata(i_index_wdata), .o_mul_go(i_mul_go), .o_div_go(i_div_go), .o_acc(i_acc),
   .o_alu_flag_we(i_alu_flag_we), .o_alu_carry(i_alu_carry), .o_alu_half_carry(i_alu_half_carry),
   .o_alu_range_err(i_alu_range_err), .o_xdata_addr(i_xdata_addr), .o_serial_irq(i_serial_irq),
   .o_ext_int_zero_pin(i_ext_int_zero_pin), .o_ext_int_zero_edge_select(i_ext_int_zero_edge_select));
csb_core_sfr_bank dut_u (.*);
// ==============================================
// Shared tasks
initial
begin
   i_sys_clk = 1'b0;
   forever #2.5 i_sys_clk = ~i_sys_clk;
end
task chk(input [23:0] seen, input [23:0] exp);
begin
   cmp_count = cmp_count + 1;
   if (seen !== exp)
   begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
   end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
   u_core.req(0, a, d, 1);
   #1;
end
endtask
task rd(input [7:0] a, input [7:0] exp, input hit);
begin
   u_core.req(1, a, 8'h00, 1);
   #1;
   chk(o_sfr_rdata, exp);
   chk(o_sfr_hit, hit);
end
endtask
task op(input integer k, input integer n);
begin
   u_core.req(k, 8'h00, 8'h00, n);
   #1;
end
endtask
// One edge drives the wake, the next samples and shows it
task wake(input serial, input level, input exp);
begin
   @(posedge i_sys_clk);
   u_core.o_serial_irq <= serial;
   u_core.o_ext_int_zero_pin <= !level;
   @(posedge i_sys_clk);
   #1;
   chk(o_sleep, exp);
   @(posedge i_sys_clk);
   u_core.o_serial_irq <= 1'b0;
   u_core.o_ext_int_zero_pin <= 1'b1;
end
endtask
task xa(input [23:0] a, input exp);
begin
   @(posedge i_sys_clk);
   u_core.o_xdata_addr <= a;
   @(posedge i_sys_clk);
   #1;
   chk(o_xdata_onchip, exp);
end
endtask
// ==============================================
// Scenarios
task t_reset;
begin
   rd(8'h81, 8'h07, 1'b1);
   rd(8'haf, 8'h00, 1'b1);
   rd(8'hd0, 8'h00, 1'b1);
   rd(8'h87, 8'h00, 1'b1);
   rd(8'h00, 8'h00, 1'b0);
   chk(o_latch_strobe_en, 1'b1);
   $display("reset values done");
end
endtask
task t_index;
begin
   u_core.req(6, 8'hff, 8'hff, 1);
   op(5, 1);
   chk(o_memory_index_pointer, 24'h010000);
   rd(8'h84, 8'h01, 1'b1);
   wr(8'h82, 8'h5a);
   rd(8'h82, 8'h5a, 1'b1);
   chk(o_memory_index_pointer, 24'h01005a);
   $display("index pointer done");
end
endtask
task t_psw;
   integer b;
begin
   for (b = 0; b < 4; b = b + 1)
   begin
      wr(8'hd0, b[7:0] << 3);
      chk(o_bank_sel, b[1:0]);
   end
   u_core.req(2, 8'hd7, 8'h01, 1);
   rd(8'hd0, 8'h98, 1'b1);
   @(posedge i_sys_clk);
   u_core.o_acc <= 8'h10;
   wr(8'hf0, 8'h10);
   op(7, 1);
   chk(o_acc_result_valid, 1'b1);
   chk(o_acc_result, 8'h00);
   rd(8'hf0, 8'h01, 1'b1);
   rd(8'hd0, 8'h1d, 1'b1);
   op(8, 1);
   chk(o_acc_result, 8'h10);
   rd(8'hf0, 8'h00, 1'b1);
   @(posedge i_sys_clk);
   u_core.o_alu_carry <= 1'b1;
   u_core.o_alu_half_carry <= 1'b1;
   u_core.req(9, 8'h00, 8'h00, 1);
   rd(8'hd0, 8'hd9, 1'b1);
   $display("status word done");
end
endtask
task t_power;
begin
   wr(8'h87, 8'h02);
   chk(o_sleep, 1'b1);
   wake(1'b1, 1'b0, 1'b1);
   wr(8'h87, 8'h42);
   wake(1'b1, 1'b0, 1'b0);
   wr(8'h87, 8'h22);
   wake(1'b0, 1'b1, 1'b0);
   @(posedge i_sys_clk);
   u_core.o_ext_int_zero_edge_select <= 1'b1;
   wr(8'h87, 8'h22);
   wake(1'b0, 1'b1, 1'b0);
   @(posedge i_sys_clk);
   u_core.o_ext_int_zero_pin <= 1'b0;
   wr(8'h87, 8'h22);
   wake(1'b0, 1'b1, 1'b1);
   wr(8'h87, 8'hff);
   rd(8'h87, 8'hfe, 1'b1);
   chk(o_baud_doubler, 1'b1);
   chk(o_latch_strobe_en, 1'b0);
   wr(8'h87, 8'h00);
   $display("power control done");
end
endtask
task t_xdata;
begin
   wr(8'haf, 8'h01);
   xa(24'h0007ff, 1'b1);
   xa(24'h000800, 1'b0);
   wr(8'haf, 8'h00);
   xa(24'h000000, 1'b0);
   xa(24'hffffff, 1'b0);
   $display("data map done");
end
endtask
task t_stack;
begin
   op(3, 1);
   chk(o_stk_addr, 11'h008);
   wr(8'h81, 8'hfe);
   op(3, 2);
   chk(o_stk_addr, 11'h000);
   wr(8'hb7, 8'h07);
   rd(8'hb7, 8'h00, 1'b0);
   wr(8'haf, 8'hff);
   rd(8'haf, 8'h81, 1'b1);
   rd(8'hb7, 8'h00, 1'b1);
   wr(8'h81, 8'hff);
   op(3, 1);
   chk(o_stk_addr, 11'h100);
   rd(8'hb7, 8'h01, 1'b1);
   wr(8'hb7, 8'hff);
   rd(8'hb7, 8'h07, 1'b1);
   op(4, 1);
   rd(8'hb7, 8'h06, 1'b1);
   wr(8'haf, 8'h00);
   op(3, 1);
   chk(o_stk_addr, 11'h000);
   $display("stack pointer done");
end
endtask
// ==============================================
// Verdict, main sequence and watchdog
task print_verdict;
begin
   $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
   if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
end
endtask
initial
begin
   i_rst_b = 1'b0;
   num_errors = 0;
   cmp_count = 0;
   repeat (12) @(posedge i_sys_clk);
   i_rst_b <= 1'b1;
   repeat (3) @(posedge i_sys_clk);
   t_reset;
   t_index;
   t_psw;
   t_power;
   t_xdata;
   t_stack;
   print_verdict;
end
// Whole run needs about 145 cycles
initial
begin
   repeat (3000) @(posedge i_sys_clk);
   num_errors = num_errors + 1;
   print_verdict;
end
endmodule
